/* File: hdl/cpfc_consts.vh */
`ifndef CPFC_CONSTS_VH
`define CPFC_CONSTS_VH
// Overview of operation
// - A bit is a frame opening with a low pulse; one adds a midframe pulse.
// - Nominal frame from one frame-start pulse to the next is 4 ms.
// - A store to the dedicated strobe location emits a pulse toward tape.
// - A held low on the sense input marks the start of a new frame.
// - A quarter frame after the start pulse, the receive latch is cleared.
// - Half a frame later sense is sampled: low is one and clears again.
// - Frame timing restarts on every start pulse so error never accumulates.
// - Receiver hunts bitwise for the ID word and stores data only afterwards.
// - The identification character is hexadecimal A5.
// - The stream carries an entry address; control passes there after a good load.
// - When sending, the hunt lamp goes on once the leader is complete.
// - Send done: hunt lamp off, transfer-done lamp on, sequencer halts.
// - When receiving, the hunt lamp stays on until the ID word is seen.
// - Receive done: transfer-done lamp on; hunt lamp on again if sums match.
// - An 8-bit sum of data is checked; mismatch lights tape-end lamp and halts.
// - Strobe offsets: 0 end on, 1 end off, 2 hunt on, 3 hunt off, 4 flag.

// ----------------------------------------------------------------------------
// Strobe area
// ----------------------------------------------------------------------------
`define CPFC_AREA_BASE 16'h8300
`define CPFC_OFS_END_SET 3'h0
`define CPFC_OFS_END_CLR 3'h1
`define CPFC_OFS_HUNT_SET 3'h2
`define CPFC_OFS_HUNT_CLR 3'h3
`define CPFC_OFS_FLAG 3'h4
`define CPFC_LAMP_RST 1'b0

// ----------------------------------------------------------------------------
// Stream format and timing
// ----------------------------------------------------------------------------
`define CPFC_ID_BYTE 8'hA5
`define CPFC_HDR_BYTES 16'h0006
`define CPFC_LEADER_BYTES 125
`define CPFC_CLK_KHZ 50000
`define CPFC_FRAME_US 4000
`define CPFC_FRAME_CYC (`CPFC_FRAME_US * `CPFC_CLK_KHZ / 1000)
`define CPFC_PULSE_US 20
`define CPFC_PULSE_CYC (`CPFC_PULSE_US * `CPFC_CLK_KHZ / 1000)
`endif

/* File: hdl/cpfc_byte_fifo.v */
module cpfc_byte_fifo #(
    parameter W = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    input wire [W-1:0] in_data,
    output reg in_ready,
    output wire out_valid,
    output wire [W-1:0] out_data,
    input wire out_ready
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;
    wire [AW:0] next_count;

    // Ready is kept in a flop so the top-level port is registered.
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // Storage and pointers; wrapping relies on DEPTH being a power of two.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready <= (next_count < DEPTH);
        end
    end
endmodule // cpfc_byte_fifo

/* File: hdl/cpfc_frame_timer.v */
module cpfc_frame_timer #(
    parameter CNT_W = 18
) (
    input wire clk,
    input wire rst_n,
    input wire restart,
    output reg [CNT_W-1:0] cnt
);
    // Counts system clocks since the last restart and parks at the top so a
    // stalled frame can never wrap into a false match.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= {CNT_W{1'b0}};
        end else if (restart) begin
            cnt <= {CNT_W{1'b0}};
        end else if (cnt != {CNT_W{1'b1}}) begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule // cpfc_frame_timer

/* File: hdl/cpfc_codec.v */
`include "cpfc_consts.vh"

module cpfc_codec #(
    parameter FRAME_CYCLES = `CPFC_FRAME_CYC,
    parameter PULSE_CYCLES = `CPFC_PULSE_CYC,
    parameter LEADER_BYTES = `CPFC_LEADER_BYTES,
    parameter CNT_W = 18,
    parameter FIFO_DEPTH = 8
) (
    input wire MCLK,
    input wire NRST,
    input wire [15:0] ADDR,
    input wire STORE,
    input wire SEND_GO,
    input wire RECV_GO,
    input wire [15:0] START_ADDR,
    input wire [15:0] ENTRY_ADDR,
    input wire [15:0] LENGTH,
    input wire TX_VALID,
    input wire [7:0] TX_DATA,
    output wire TX_READY,
    input wire SENSE_N,
    output reg TAPE_PULSE_N,
    output reg LATCH_CLR,
    output reg TAPE_END_LAMP,
    output reg HUNT_LAMP,
    output reg BUSY,
    output reg RX_WE,
    output reg [15:0] RX_ADDR,
    output reg [7:0] RX_DATA,
    output reg [15:0] RX_ENTRY,
    output reg RX_JUMP
);
    // ------------------------------------------------------------------------
    // Local codes and interval lengths
    // ------------------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_TLOAD = 3'h1;
    localparam [2:0] ST_TBIT = 3'h2;
    localparam [2:0] ST_RLOW = 3'h3;
    localparam [2:0] ST_RQTR = 3'h4;
    localparam [2:0] ST_RHALF = 3'h5;
    localparam [2:0] ST_RHIGH = 3'h6;
    localparam [2:0] PH_LEAD = 3'h0;
    localparam [2:0] PH_ID = 3'h1;
    localparam [2:0] PH_HDR = 3'h2;
    localparam [2:0] PH_DATA = 3'h3;
    localparam [2:0] PH_SUM = 3'h4;
    localparam [CNT_W-1:0] QTR_CYC = FRAME_CYCLES / 4;
    localparam [CNT_W-1:0] SAMPLE_CYC = FRAME_CYCLES / 4 + FRAME_CYCLES / 2;
    localparam [CNT_W-1:0] HALF_CYC = FRAME_CYCLES / 2;
    localparam [CNT_W-1:0] LAST_CYC = FRAME_CYCLES - 2;
    localparam [15:0] LEAD_LAST = LEADER_BYTES - 1;
    localparam [15:0] PULSE_LAST = PULSE_CYCLES - 1;

    reg [2:0] st;
    reg [2:0] ph;
    reg sending;
    reg [15:0] cnt;
    reg [2:0] bitn;
    reg [7:0] shreg;
    reg [7:0] sum;
    reg [47:0] hdr;
    reg [15:0] tx_start;
    reg [15:0] tx_entry;
    reg [15:0] tx_len;
    reg tmr_restart;
    reg pulse_req;
    reg [15:0] pcnt;
    reg sense_s1;
    reg sense_s2;
    wire bit_in;
    wire [7:0] new_byte;
    wire [CNT_W-1:0] tcnt;
    wire fifo_valid;
    wire [7:0] fifo_data;
    wire fifo_pop;
    wire area_hit;
    wire [2:0] ofs;
    wire sense_low;
    wire [15:0] rx_len;

    // Header order on tape: start, entry, length, low byte before high.
    function [7:0] hdr_pick;
        input [2:0] idx;
        input [15:0] start;
        input [15:0] entry;
        input [15:0] len;
        begin
            case (idx)
                3'h0: hdr_pick = start[7:0];
                3'h1: hdr_pick = start[15:8];
                3'h2: hdr_pick = entry[7:0];
                3'h3: hdr_pick = entry[15:8];
                3'h4: hdr_pick = len[7:0];
                3'h5: hdr_pick = len[15:8];
                default: hdr_pick = 8'h00;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------------
    cpfc_frame_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .clk(MCLK),
        .rst_n(NRST),
        .restart(tmr_restart),
        .cnt(tcnt)
    );

    // Payload waits here; back-pressure reaches the source through TX_READY.
    cpfc_byte_fifo #(
        .W(8),
        .DEPTH(FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(NRST),
        .in_valid(TX_VALID),
        .in_data(TX_DATA),
        .in_ready(TX_READY),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_pop)
    );

    // Strobe decode of the peripheral area and the payload pop.
    assign area_hit = STORE && ({ADDR[15:3], 3'h0} == `CPFC_AREA_BASE);
    assign ofs = ADDR[2:0];
    assign fifo_pop = (st == ST_TLOAD) && (ph == PH_DATA) && fifo_valid;
    assign sense_low = ~sense_s2;
    assign rx_len = hdr[47:32];
    assign bit_in = sense_low;
    assign new_byte = {sense_low, shreg[7:1]};

    // ------------------------------------------------------------------------
    // Sense synchroniser
    // ------------------------------------------------------------------------
    // The latch is set by the analog side with no relation to MCLK.
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            sense_s1 <= 1'b1;
            sense_s2 <= 1'b1;
        end else begin
            sense_s1 <= SENSE_N;
            sense_s2 <= sense_s1;
        end
    end

    // ------------------------------------------------------------------------
    // Tape pulse generator
    // ------------------------------------------------------------------------
    // A request during a running pulse is merged; midframe spacing is far wider.
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            pcnt <= 16'h0000;
            TAPE_PULSE_N <= 1'b1;
        end else if (pulse_req) begin
            pcnt <= PULSE_LAST;
            TAPE_PULSE_N <= 1'b0;
        end else if (pcnt != 16'h0000) begin
            pcnt <= pcnt - 16'h0001;
        end else begin
            TAPE_PULSE_N <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer for send and receive, lamps and strobes
    // ------------------------------------------------------------------------
    // Later assignments win, so strobe sets come last and beat any clear.
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            st <= ST_IDLE;
            ph <= PH_LEAD;
            sending <= 1'b0;
            cnt <= 16'h0000;
            bitn <= 3'h0;
            shreg <= 8'h00;
            sum <= 8'h00;
            hdr <= 48'h000000000000;
            tx_start <= 16'h0000;
            tx_entry <= 16'h0000;
            tx_len <= 16'h0000;
            tmr_restart <= 1'b0;
            pulse_req <= 1'b0;
            LATCH_CLR <= 1'b0;
            TAPE_END_LAMP <= `CPFC_LAMP_RST;
            HUNT_LAMP <= `CPFC_LAMP_RST;
            BUSY <= 1'b0;
            RX_WE <= 1'b0;
            RX_ADDR <= 16'h0000;
            RX_DATA <= 8'h00;
            RX_ENTRY <= 16'h0000;
            RX_JUMP <= 1'b0;
        end else begin
            tmr_restart <= 1'b0;
            pulse_req <= 1'b0;
            LATCH_CLR <= 1'b0;
            RX_WE <= 1'b0;
            RX_JUMP <= 1'b0;
            if (area_hit && ofs == `CPFC_OFS_END_CLR) begin
                TAPE_END_LAMP <= 1'b0;
            end
            if (area_hit && ofs == `CPFC_OFS_HUNT_CLR) begin
                HUNT_LAMP <= 1'b0;
            end
            case (st)
                ST_IDLE: begin
                    if (SEND_GO) begin
                        tx_start <= START_ADDR;
                        tx_entry <= ENTRY_ADDR;
                        tx_len <= LENGTH;
                        sending <= 1'b1;
                        ph <= PH_LEAD;
                        cnt <= 16'h0000;
                        sum <= 8'h00;
                        HUNT_LAMP <= 1'b0;
                        TAPE_END_LAMP <= 1'b0;
                        BUSY <= 1'b1;
                        st <= ST_TLOAD;
                    end else if (RECV_GO) begin
                        sending <= 1'b0;
                        ph <= PH_ID;
                        shreg <= 8'h00;
                        sum <= 8'h00;
                        HUNT_LAMP <= 1'b1;
                        TAPE_END_LAMP <= 1'b0;
                        BUSY <= 1'b1;
                        st <= ST_RLOW;
                    end
                end
                ST_TLOAD: begin
                    // The source stalls only the data phase; other bytes are built here.
                    if (ph != PH_DATA || fifo_valid) begin
                        case (ph)
                            PH_LEAD: shreg <= 8'h00;
                            PH_ID: shreg <= `CPFC_ID_BYTE;
                            PH_HDR: shreg <= hdr_pick(cnt[2:0], tx_start, tx_entry, tx_len);
                            PH_DATA: shreg <= fifo_data;
                            default: shreg <= sum;
                        endcase
                        if (ph == PH_DATA) begin
                            sum <= sum + fifo_data;
                        end
                        bitn <= 3'h0;
                        tmr_restart <= 1'b1;
                        pulse_req <= 1'b1;
                        st <= ST_TBIT;
                    end
                end
                ST_TBIT: begin
                    if (!tmr_restart && tcnt == HALF_CYC && shreg[0]) begin
                        pulse_req <= 1'b1;
                    end
                    if (!tmr_restart && tcnt == LAST_CYC) begin
                        shreg <= {1'b0, shreg[7:1]};
                        bitn <= bitn + 3'h1;
                        if (bitn != 3'h7) begin
                            tmr_restart <= 1'b1;
                            pulse_req <= 1'b1;
                        end else begin
                            st <= ST_TLOAD;
                            cnt <= cnt + 16'h0001;
                            case (ph)
                                PH_LEAD: begin
                                    if (cnt == LEAD_LAST) begin
                                        ph <= PH_ID;
                                        HUNT_LAMP <= 1'b1;
                                    end
                                end
                                PH_ID: begin
                                    ph <= PH_HDR;
                                    cnt <= 16'h0000;
                                end
                                PH_HDR: begin
                                    if (cnt == `CPFC_HDR_BYTES - 16'h0001) begin
                                        ph <= (tx_len == 16'h0000) ? PH_SUM : PH_DATA;
                                        cnt <= 16'h0000;
                                    end
                                end
                                PH_DATA: begin
                                    if (cnt == tx_len - 16'h0001) begin
                                        ph <= PH_SUM;
                                    end
                                end
                                default: begin
                                    HUNT_LAMP <= 1'b0;
                                    TAPE_END_LAMP <= 1'b1;
                                    BUSY <= 1'b0;
                                    st <= ST_IDLE;
                                end
                            endcase
                        end
                    end
                end
                ST_RLOW: begin
                    if (sense_low) begin
                        tmr_restart <= 1'b1;
                        st <= ST_RQTR;
                    end
                end
                ST_RQTR: begin
                    if (!tmr_restart && tcnt == QTR_CYC) begin
                        LATCH_CLR <= 1'b1;
                        st <= ST_RHALF;
                    end
                end
                ST_RHALF: begin
                    if (tcnt == SAMPLE_CYC) begin
                        LATCH_CLR <= bit_in;
                        shreg <= new_byte;
                        st <= ST_RHIGH;
                        if (ph == PH_ID) begin
                            if (new_byte == `CPFC_ID_BYTE) begin
                                ph <= PH_HDR;
                                HUNT_LAMP <= 1'b0;
                                bitn <= 3'h0;
                                cnt <= 16'h0000;
                            end
                        end else begin
                            bitn <= bitn + 3'h1;
                        end
                        if (ph != PH_ID && bitn == 3'h7) begin
                            cnt <= cnt + 16'h0001;
                            case (ph)
                                PH_HDR: begin
                                    hdr[cnt[2:0]*8 +: 8] <= new_byte;
                                    if (cnt == `CPFC_HDR_BYTES - 16'h0001) begin
                                        cnt <= 16'h0000;
                                        ph <= ({new_byte, hdr[39:32]} == 16'h0000) ?
                                            PH_SUM : PH_DATA;
                                    end
                                end
                                PH_DATA: begin
                                    RX_WE <= 1'b1;
                                    RX_ADDR <= hdr[15:0] + cnt;
                                    RX_DATA <= new_byte;
                                    sum <= sum + new_byte;
                                    if (cnt == rx_len - 16'h0001) begin
                                        ph <= PH_SUM;
                                    end
                                end
                                default: begin
                                    TAPE_END_LAMP <= 1'b1;
                                    BUSY <= 1'b0;
                                    st <= ST_IDLE;
                                    if (new_byte == sum) begin
                                        HUNT_LAMP <= 1'b1;
                                        RX_ENTRY <= hdr[31:16];
                                        RX_JUMP <= 1'b1;
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_RHIGH: begin
                    // Keep clearing until the synchronised latch reads high again.
                    if (sense_low) begin
                        LATCH_CLR <= 1'b1;
                    end else begin
                        st <= ST_RLOW;
                    end
                end
                default: st <= ST_IDLE;
            endcase
            if (area_hit && ofs == `CPFC_OFS_FLAG) begin
                pulse_req <= 1'b1;
                LATCH_CLR <= 1'b1;
            end
            if (area_hit && ofs == `CPFC_OFS_END_SET) begin
                TAPE_END_LAMP <= 1'b1;
            end
            if (area_hit && ofs == `CPFC_OFS_HUNT_SET) begin
                HUNT_LAMP <= 1'b1;
            end
        end
    end
endmodule // cpfc_codec

/* File: verification/cpfc_codec_monitor.sv */
module cpfc_codec_monitor #(
    parameter int PULSE_CYCLES = 8
) (
    input wire MCLK,
    input wire NRST,
    input wire [15:0] ADDR,
    input wire STORE,
    input wire SEND_GO,
    input wire RECV_GO,
    input wire TAPE_PULSE_N,
    input wire LATCH_CLR,
    input wire TAPE_END_LAMP,
    input wire HUNT_LAMP,
    input wire BUSY,
    input wire RX_WE
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Port checks
    // ----------------------------------------
    int low_cnt;
    // Strobes are judged only while idle, since the sequencer also drives the lamps.
    wire hit = STORE && ADDR[15:3] == 13'h1060 && !BUSY;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);
    // Counts low cycles of the tape line; a counter avoids a long repetition.
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) low_cnt <= 0;
        else low_cnt <= TAPE_PULSE_N ? 0 : low_cnt + 1;
    end
    property p_width; $rose(TAPE_PULSE_N) |-> low_cnt == PULSE_CYCLES; endproperty
    a_width: assert property (p_width) else $error("tape pulse width");
    property p_flag; hit && ADDR[2:0] == 3'h4 |=> LATCH_CLR ##1 !LATCH_CLR && !TAPE_PULSE_N;
    endproperty
    a_flag: assert property (p_flag) else $error("flag strobe");
    property p_end_on; hit && ADDR[2:0] == 3'h0 |=> TAPE_END_LAMP; endproperty
    a_end_on: assert property (p_end_on) else $error("end lamp set");
    property p_end_off; hit && ADDR[2:0] == 3'h1 |=> !TAPE_END_LAMP; endproperty
    a_end_off: assert property (p_end_off) else $error("end lamp clear");
    property p_hunt_on; hit && ADDR[2:0] == 3'h2 |=> HUNT_LAMP; endproperty
    a_hunt_on: assert property (p_hunt_on) else $error("hunt lamp set");
    property p_hunt_off; hit && ADDR[2:0] == 3'h3 |=> !HUNT_LAMP; endproperty
    a_hunt_off: assert property (p_hunt_off) else $error("hunt lamp clear");
    property p_send; SEND_GO && !BUSY |=> BUSY && !HUNT_LAMP ##2 !TAPE_PULSE_N; endproperty
    a_send: assert property (p_send) else $error("send start");
    property p_recv; RECV_GO && !SEND_GO && !BUSY |=> BUSY && HUNT_LAMP && !TAPE_END_LAMP;
    endproperty
    a_recv: assert property (p_recv) else $error("receive start");
    property p_done; $fell(BUSY) |-> ##[0:2] TAPE_END_LAMP; endproperty
    a_done: assert property (p_done) else $error("done lamp");
    property p_we; RX_WE |-> BUSY ##1 !RX_WE; endproperty
    a_we: assert property (p_we) else $error("write pulse");
endmodule // cpfc_codec_monitor

/* File: verification/cpfc_tape_model.sv */
module cpfc_tape_model #(
    parameter int FRAME = 160
) (
    input wire MCLK,
    input wire TAPE_PULSE_N,
    input wire LATCH_CLR,
    output logic SENSE_N
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Recorder and receive latch
    // ----------------------------------------
    bit bits[$];
    int since = 100000;
    logic prev_n = 1'b1, cur = 1'b0, open = 1'b0, set_req = 1'b0;
    initial SENSE_N = 1'b1;
    // A pulse far from the last start opens a frame; one near its middle marks a one.
    always @(posedge MCLK) begin
        prev_n <= TAPE_PULSE_N;
        since <= since + 1;
        if (prev_n && !TAPE_PULSE_N) begin
            if (since > FRAME * 3 / 4) begin
                if (open) bits.push_back(cur);
                open <= 1'b1;
                cur <= 1'b0;
                since <= 1;
            end else cur <= 1'b1;
        end
        if (set_req) SENSE_N <= 1'b0;
        else if (LATCH_CLR) SENSE_N <= 1'b1;
    end
    // Stray flag pulses before a recording must not leave a frame open.
    task automatic clear();
        bits.delete();
        since = 100000;
        open = 1'b0;
    endtask
    task automatic flush();
        if (open) bits.push_back(cur);
        open = 1'b0;
    endtask
    // Replays at a fixed frame rate; flip inverts the final bit to spoil the sum.
    task automatic play(input bit flip);
        for (int i = 0; i < bits.size(); i++) begin
            set_req = 1'b1;
            @(posedge MCLK);
            #1 set_req = 1'b0;
            repeat (FRAME / 2 - 1) @(posedge MCLK);
            #1 set_req = bits[i] ^ (flip && i == bits.size() - 1);
            @(posedge MCLK);
            #1 set_req = 1'b0;
            repeat (FRAME / 2 - 1) @(posedge MCLK);
            #1;
        end
    endtask
endmodule // cpfc_tape_model

/* File: verification/cpfc_codec_tb_top.sv */
module cpfc_codec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Bench
    // ----------------------------------------
    localparam int FR = 160;
    logic MCLK = 1'b0, NRST = 1'b0, STORE = 1'b0, SEND_GO = 1'b0, RECV_GO = 1'b0;
    logic TX_VALID = 1'b0;
    logic [7:0] TX_DATA = 8'h00;
    logic [15:0] ADDR = 16'h0000, START_ADDR = 16'h1200, ENTRY_ADDR = 16'h1234;
    logic [15:0] LENGTH = 16'h0008;
    wire TX_READY, SENSE_N, TAPE_PULSE_N, LATCH_CLR, TAPE_END_LAMP, HUNT_LAMP, BUSY;
    wire RX_WE, RX_JUMP;
    wire [15:0] RX_ADDR, RX_ENTRY;
    wire [7:0] RX_DATA;
    int n_mismatch = 0, samples_checked = 0, n_we = 0, n_jump = 0;
    logic [7:0] b;
    logic [7:0] stream [18] = '{8'h00, 8'h00, 8'hA5, 8'h00, 8'h12, 8'h34, 8'h12, 8'h08,
        8'h00, 8'h3C, 8'h65, 8'h8E, 8'hB7, 8'hE0, 8'h09, 8'h32, 8'h5B, 8'h5C};
    logic [15:0] tab [8] = '{16'h8302, 16'h8300, 16'h8305, 16'h8306, 16'h8307, 16'h8B03,
        16'h8303, 16'h8301};
    cpfc_codec #(.FRAME_CYCLES(FR), .PULSE_CYCLES(8), .LEADER_BYTES(2)) cpfc_codec_inst (.*);
    cpfc_tape_model #(.FRAME(FR)) cpfc_tape_model_inst (.*);
    initial begin
        forever #10 MCLK = ~MCLK;
    end
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Bounded wait for the sequencer to halt; running out ends the run.
    task automatic wait_idle();
        int k;
        k = 0;
        while (BUSY !== 1'b0 && k < 40000) begin
            @(posedge MCLK);
            k++;
        end
        #1;
        if (k == 40000) begin
            chk_bit(1'b1, 1'b0);
            print_verdict();
        end
    endtask
    task automatic store(input logic [15:0] a);
        @(posedge MCLK);
        #1 ADDR = a;
        STORE = 1'b1;
        @(posedge MCLK);
        #1 STORE = 1'b0;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge MCLK);
        #1 s = 1'b0;
    endtask
    task automatic rx(input bit flip);
        n_we = 0;
        pulse(RECV_GO);
        chk_bit(HUNT_LAMP & !TAPE_END_LAMP, 1'b1);
        fork
            cpfc_tape_model_inst.play(flip);
            begin
                repeat (28 * FR) @(posedge MCLK);
                #1 chk_bit(HUNT_LAMP, 1'b0);
            end
        join
        wait_idle();
        chk_word(16'(n_we), 16'h0008);
    endtask
    // Received bytes must land at start plus index; a jump must carry the entry point.
    always @(posedge MCLK) begin
        if (RX_WE === 1'b1) begin
            chk_word(RX_ADDR, START_ADDR + 16'(n_we));
            chk_word({8'h00, RX_DATA}, {8'h00, stream[9 + n_we]});
            n_we++;
        end
        if (RX_JUMP === 1'b1) begin
            chk_word(RX_ENTRY, ENTRY_ADDR);
            n_jump++;
        end
    end
    // Strobes, buffer fill, one recording, a clean replay, then a spoiled one.
    initial begin
        repeat (20) @(posedge MCLK);
        #1 NRST = 1'b1;
        chk_bit(TAPE_PULSE_N & TX_READY, 1'b1);
        chk_bit(BUSY | HUNT_LAMP | TAPE_END_LAMP | LATCH_CLR, 1'b0);
        for (int i = 0; i < 8; i++) begin
            store(tab[i]);
            chk_bit(HUNT_LAMP, 8'b00111111 >> i);
            chk_bit(TAPE_END_LAMP, 8'b01111110 >> i);
        end
        store(16'h8304);
        chk_bit(LATCH_CLR, 1'b1);
        @(posedge MCLK);
        #1 chk_bit(TAPE_PULSE_N | LATCH_CLR, 1'b0);
        repeat (8) @(posedge MCLK);
        #1 chk_bit(TAPE_PULSE_N, 1'b1);
        for (int i = 0; i < 8; i++) begin
            chk_bit(TX_READY, 1'b1);
            TX_DATA = stream[9 + i];
            TX_VALID = 1'b1;
            @(posedge MCLK);
            #1;
        end
        TX_VALID = 1'b0;
        @(posedge MCLK);
        #1 chk_bit(TX_READY, 1'b0);
        cpfc_tape_model_inst.clear();
        pulse(SEND_GO);
        repeat (16 * FR - 20) @(posedge MCLK);
        #1 chk_bit(HUNT_LAMP, 1'b0);
        repeat (FR) @(posedge MCLK);
        #1 chk_bit(HUNT_LAMP, 1'b1);
        wait_idle();
        cpfc_tape_model_inst.flush();
        chk_bit(!HUNT_LAMP & TAPE_END_LAMP & TX_READY, 1'b1);
        chk_word(16'(cpfc_tape_model_inst.bits.size()), 16'h0090);
        for (int j = 0; j < 18; j++) begin
            for (int k = 0; k < 8; k++) b[k] = cpfc_tape_model_inst.bits[8 * j + k];
            chk_word({8'h00, b}, {8'h00, stream[j]});
        end
        rx(1'b0);
        chk_bit(HUNT_LAMP & TAPE_END_LAMP, 1'b1);
        chk_word(16'(n_jump), 16'h0001);
        rx(1'b1);
        chk_bit(TAPE_END_LAMP & !HUNT_LAMP, 1'b1);
        chk_word(16'(n_jump), 16'h0001);
        print_verdict();
    end
endmodule // cpfc_codec_tb_top

bind cpfc_codec cpfc_codec_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) cpfc_codec_monitor_inst (.*);
